// ===== common/hsa_defines.vh
// hsa_defines.vh: constants of the actuator status aggregator
// assumes: included by bare name from the design and verification files, no other dependencies
`ifndef HSA_DEFINES_VH
`define HSA_DEFINES_VH

// register byte addresses on the apb bus
`define HSA_OFF_CTRL 12'h000
`define HSA_OFF_POS_ZERO 12'h004
`define HSA_OFF_POS_GAIN 12'h008
`define HSA_OFF_TRQ_SCALE 12'h00c
`define HSA_OFF_FIX_VAL 12'h010
`define HSA_OFF_DEV_STAT 12'h014
`define HSA_OFF_PV_SV 12'h018
`define HSA_OFF_TV_QV 12'h01c
`define HSA_OFF_EXT0 12'h020
`define HSA_OFF_EXT4 12'h030

// control register fields
`define HSA_CTRL_TV_ALT 0
`define HSA_CTRL_QV_ALT 1
`define HSA_CTRL_TV_FIX 2
`define HSA_CTRL_QV_FIX 3
`define HSA_CTRL_SELFTEST 8

// reset values
`define HSA_RST_CTRL 4'h0
`define HSA_RST_POS_ZERO 16'h0000
`define HSA_RST_POS_GAIN 16'h0000
`define HSA_RST_TRQ_SCALE 16'h0100
`define HSA_RST_FIX_VAL 16'h0000

// device variable numbers behind pv, sv, tv, qv
`define HSA_DVN_PV 8'h00
`define HSA_DVN_SV 8'h01
`define HSA_DVN_TV 8'h02
`define HSA_DVN_QV 8'h03
`define HSA_DVN_POS2 8'h04
`define HSA_DVN_PRES2 8'h05
`define HSA_DVN_FIXED 8'h06

// loop current scaling, currents in microamps
`define HSA_LOOP_MIN_UA 17'h00fa0
`define HSA_LOOP_SPAN_UA 17'h03e80
`define HSA_PCT_FULL 16'h2710

// torque unit code, pound-force inches
`define HSA_UNIT_TORQUE 8'hf0

// device status byte fields
`define HSA_DS_MORE 4
`define HSA_DS_ALERT 7

// extended status: bytes 0..5 conditions, bytes 14..18 drive detail
`define HSA_NCOND 46
`define HSA_NDRV 40
`define HSA_EXT_BYTES 19
`define HSA_BYTE6_WARN 48
`define HSA_BYTE6_ALARM 49
`define HSA_DRV_BASE 112
`define HSA_ALARM_MASK 46'h0600_1081_f400
`define HSA_OPT_MASK 46'h3f_ff_b1_fe_0b_ee

`endif

// ===== hw/hsa_status.v
// hsa_status.v: status and variable reporting core of a 4-20 ma loop actuator
// assumes: one 250 mhz clock, apb register access, condition and sensor
// inputs come from logic on the same clock, the reply framer reads outputs.
//
// How it works
// RULE1 - pv is setpoint, sv position, tv torque, qv accumulator pressure.
// RULE2 - tv and qv may carry secondary position or pressure, or a fixed test value.
// RULE3 - torque is close minus open pressure times model scale, signed by direction.
// RULE4 - accumulator loop current 4 to 20 ma maps linearly onto 0 to 3000 psi.
// RULE5 - control loop current is the position setpoint, reported in percent.
// RULE6 - position is reported as percent of the calibrated stroke span.
// RULE7 - device status bit 4 is set while any extended condition is active.
// RULE8 - host reads the extended status after seeing bit 4 set.
// RULE9 - extended status answer is exactly 19 bytes.
// RULE10 - alarm conditions set status bits 4 and 7, warnings only bit 4.
// RULE11 - condition bits sit in bytes 0 to 5, each with a fixed class.
// RULE12 - byte 6 bit 0 is high when any warning bit is set.
// RULE13 - byte 6 bit 1 is high when any alarm bit is set.
// RULE14 - bits of optional hardware are never set on models without it.
// RULE15 - primary and dual drive detail from byte 14 bit 0, ten bits each.
// RULE16 - accumulator drive from byte 16 bit 4, booster up to byte 18 bit 7, warnings.
// RULE17 - startup and reset self-test may set and clear every condition bit.
// RULE18 - background self-test only sets bits, never clears them.
// RULE19 - torque is reported with unit code 240, pound-force inches.
// RULE20 - no burst mode: nothing is sent unless the host asks.
// RULE21 - bytes 7 to 13 and unused bit positions read as zero.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "hsa_defines.vh"

module hsa_status #(
   parameter [`HSA_NCOND-1:0] P_FIT_COND = {`HSA_NCOND{1'b1}},
   parameter [`HSA_NDRV-1:0] P_FIT_DRV = {`HSA_NDRV{1'b1}}
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire o_pready,
   output wire [31:0] o_prdata,
   output wire o_pslverr,
   // reset command from the protocol layer
   input wire i_reset_cmd,
   // self-test interface
   output wire o_selftest_req,
   input wire i_selftest_done,
   input wire [`HSA_NCOND-1:0] i_selftest_cond,
   input wire [`HSA_NDRV-1:0] i_selftest_drv,
   input wire [`HSA_NCOND-1:0] i_bg_cond,
   input wire [`HSA_NDRV-1:0] i_bg_drv,
   // measured quantities
   input wire [15:0] i_ctl_ua,
   input wire [15:0] i_acc_ua,
   input wire [15:0] i_pos_raw,
   input wire [15:0] i_close_press,
   input wire [15:0] i_open_press,
   input wire [15:0] i_pos2,
   input wire [15:0] i_press2,
   // reported values
   output wire [15:0] o_pv,
   output wire [15:0] o_sv,
   output wire [15:0] o_tv,
   output wire [15:0] o_qv,
   output wire [7:0] o_tv_dvn,
   output wire [7:0] o_qv_dvn,
   output wire [7:0] o_tv_unit,
   output wire [7:0] o_dev_status,
   output wire [8*`HSA_EXT_BYTES-1:0] o_ext_status
);

   // clamp a loop current to its 4..20 ma span, result 0..16000 microamps;
   // a broken loop reads below 4 ma and would otherwise wrap to a huge value,
   // so the floor is checked on the raw input before the subtraction is used.
   // currents above 20 ma saturate at full span rather than reporting over
   // range, which keeps pv and qv inside their documented limits.
   function [16:0] hsa_loop_span;
      input [15:0] ua;
      reg [16:0] d;
      begin
         d = {1'b0, ua} - `HSA_LOOP_MIN_UA;
         if (ua < `HSA_LOOP_MIN_UA) begin
            hsa_loop_span = 17'h00000;
         end else if (d > `HSA_LOOP_SPAN_UA) begin
            hsa_loop_span = `HSA_LOOP_SPAN_UA;
         end else begin
            hsa_loop_span = d;
         end
      end
   endfunction

   reg [3:0] ctrl_ff;
   reg [15:0] pos_zero_ff, pos_gain_ff, trq_scale_ff, fix_val_ff;
   reg [`HSA_NCOND-1:0] cond_ff;
   reg [`HSA_NDRV-1:0] drv_ff;
   reg st_req_ff;
   reg pready_ff, pslverr_ff;
   reg [31:0] prdata_ff;
   reg [15:0] pv_ff, sv_ff, tv_ff, qv_ff;
   reg [7:0] tv_dvn_ff, qv_dvn_ff, tv_unit_ff, dev_status_ff;
   reg [8*`HSA_EXT_BYTES-1:0] ext_ff;

   // optional bits survive only where the model has the hardware
   wire [`HSA_NCOND-1:0] cond_keep = ~`HSA_OPT_MASK | P_FIT_COND; // RULE14
   wire [`HSA_NDRV-1:0] drv_keep = P_FIT_DRV; // RULE14

   // apb decode; writes land at the edge that sees pready high
   wire apb_access = i_psel & i_penable;
   wire apb_commit = apb_access & pready_ff;
   wire apb_wr = apb_commit & i_pwrite;
   wire cmd_selftest = apb_wr & (i_paddr == `HSA_OFF_CTRL) & i_pwdata[`HSA_CTRL_SELFTEST];

   // condition classes
   // the alarm mask marks the alarm-class positions of bytes 0..5; all other
   // condition bits and every drive detail bit are warning class.
   // the summaries are built from the registered set, so the summary bits,
   // the device status byte and the image all move on the same edge.
   wire any_alarm = |(cond_ff & `HSA_ALARM_MASK); // RULE10
   wire any_warn = |(cond_ff & ~`HSA_ALARM_MASK) | (|drv_ff); // RULE16
   wire any_cond = any_alarm | any_warn;

   // next condition state: a startup or reset self-test result replaces the set,
   // background failures are ored in so a failure in the load cycle still lands
   reg [`HSA_NCOND-1:0] nxt_cond;
   reg [`HSA_NDRV-1:0] nxt_drv;
   always @* begin
      if (i_selftest_done) begin
         nxt_cond = i_selftest_cond | i_bg_cond; // RULE17
         nxt_drv = i_selftest_drv | i_bg_drv; // RULE17
      end else begin
         nxt_cond = cond_ff | i_bg_cond; // RULE18
         nxt_drv = drv_ff | i_bg_drv; // RULE18
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         cond_ff <= {`HSA_NCOND{1'b0}};
         drv_ff <= {`HSA_NDRV{1'b0}};
      end else if (i_ce) begin
         cond_ff <= nxt_cond & cond_keep; // RULE11 RULE14
         drv_ff <= nxt_drv & drv_keep; // RULE15 RULE16
      end
   end

   // self-test request: loaded high by reset and held through it (power-up), then raised on a reset command and on a control write with the self-test bit
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_req_ff <= 1'b1;
      end else if (i_ce) begin
         st_req_ff <= i_reset_cmd | cmd_selftest; // RULE17
      end
   end

   // extended status image, 19 bytes, unlisted positions stay zero
   // layout: bytes 0..5 condition bits, byte 6 the two class summaries,
   // bytes 7..13 reserved, bytes 14..18 the drive detail groups.
   // the image is registered so a reply framer reading it mid-update
   // never sees a half-written set.
   reg [8*`HSA_EXT_BYTES-1:0] nxt_ext;
   always @* begin
      nxt_ext = {(8*`HSA_EXT_BYTES){1'b0}}; // RULE21
      nxt_ext[`HSA_NCOND-1:0] = cond_ff; // RULE11
      nxt_ext[`HSA_BYTE6_WARN] = any_warn; // RULE12
      nxt_ext[`HSA_BYTE6_ALARM] = any_alarm; // RULE13
      nxt_ext[`HSA_DRV_BASE +: `HSA_NDRV] = drv_ff; // RULE15 RULE16
   end

   // device status byte, carried by every reply the framer builds
   reg [7:0] nxt_dev_status;
   always @* begin
      nxt_dev_status = 8'h00;
      nxt_dev_status[`HSA_DS_MORE] = any_cond; // RULE7 RULE10
      nxt_dev_status[`HSA_DS_ALERT] = any_alarm; // RULE10
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ext_ff <= {(8*`HSA_EXT_BYTES){1'b0}};
         dev_status_ff <= 8'h00;
      end else if (i_ce) begin
         ext_ff <= nxt_ext; // RULE9
         dev_status_ff <= nxt_dev_status;
      end
   end

   // setpoint in 0.01 %: (ua - 4000) * 10000 / 16000 = span * 5 / 8
   wire [16:0] ctl_span = hsa_loop_span(i_ctl_ua);
   wire [19:0] ctl_x5 = {3'b000, ctl_span} * 20'h00005;
   wire [15:0] nxt_pv = ctl_x5[18:3]; // RULE5

   // accumulator in psi: (ua - 4000) * 3000 / 16000 = span * 3 / 16
   wire [16:0] acc_span = hsa_loop_span(i_acc_ua);
   wire [19:0] acc_x3 = {3'b000, acc_span} * 20'h00003;
   wire [15:0] acc_psi = acc_x3[19:4]; // RULE4

   // position: offset from calibrated zero times software gain, 16 fractional bits;
   // the gain is the reciprocal of the span so no divider is needed
   wire [15:0] pos_off = (i_pos_raw > pos_zero_ff) ? (i_pos_raw - pos_zero_ff) : 16'h0000;
   wire [31:0] pos_prod = pos_off * pos_gain_ff;
   wire [15:0] nxt_sv = (pos_prod[31:16] > `HSA_PCT_FULL) ? `HSA_PCT_FULL : pos_prod[31:16]; // RULE6

   // torque: positive when close pressure exceeds open (extending or cw);
   // the product is not saturated, so the scale must keep it within 16 bits
   wire signed [16:0] trq_diff = $signed({1'b0, i_close_press}) - $signed({1'b0, i_open_press});
   wire signed [32:0] trq_prod = trq_diff * $signed(trq_scale_ff);
   wire [15:0] trq_val = trq_prod[23:8]; // RULE3

   // dynamic variable selection, substitutes when sensing is absent
   reg [15:0] nxt_tv, nxt_qv;
   reg [7:0] nxt_tv_dvn, nxt_qv_dvn;
   always @* begin
      if (ctrl_ff[`HSA_CTRL_TV_FIX]) begin
         nxt_tv = fix_val_ff; // RULE2
         nxt_tv_dvn = `HSA_DVN_FIXED;
      end else if (ctrl_ff[`HSA_CTRL_TV_ALT]) begin
         nxt_tv = i_pos2; // RULE2
         nxt_tv_dvn = `HSA_DVN_POS2;
      end else begin
         nxt_tv = trq_val; // RULE1
         nxt_tv_dvn = `HSA_DVN_TV;
      end
      if (ctrl_ff[`HSA_CTRL_QV_FIX]) begin
         nxt_qv = fix_val_ff; // RULE2
         nxt_qv_dvn = `HSA_DVN_FIXED;
      end else if (ctrl_ff[`HSA_CTRL_QV_ALT]) begin
         nxt_qv = i_press2; // RULE2
         nxt_qv_dvn = `HSA_DVN_PRES2;
      end else begin
         nxt_qv = acc_psi; // RULE1
         nxt_qv_dvn = `HSA_DVN_QV;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         pv_ff <= 16'h0000;
         sv_ff <= 16'h0000;
         tv_ff <= 16'h0000;
         qv_ff <= 16'h0000;
         tv_dvn_ff <= `HSA_DVN_TV;
         qv_dvn_ff <= `HSA_DVN_QV;
         tv_unit_ff <= `HSA_UNIT_TORQUE;
      end else if (i_ce) begin
         pv_ff <= nxt_pv; // RULE1
         sv_ff <= nxt_sv; // RULE1
         tv_ff <= nxt_tv;
         qv_ff <= nxt_qv;
         tv_dvn_ff <= nxt_tv_dvn;
         qv_dvn_ff <= nxt_qv_dvn;
         tv_unit_ff <= `HSA_UNIT_TORQUE; // RULE19
      end
   end

   // register writes
   // only the five writable words are decoded; writes elsewhere are refused
   // with pslverr and leave every register untouched.
   // the self-test bit of the control word is a strobe and is not stored.
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_ff <= `HSA_RST_CTRL;
         pos_zero_ff <= `HSA_RST_POS_ZERO;
         pos_gain_ff <= `HSA_RST_POS_GAIN;
         trq_scale_ff <= `HSA_RST_TRQ_SCALE;
         fix_val_ff <= `HSA_RST_FIX_VAL;
      end else if (i_ce && apb_wr) begin
         case (i_paddr)
            `HSA_OFF_CTRL: ctrl_ff <= i_pwdata[3:0];
            `HSA_OFF_POS_ZERO: pos_zero_ff <= i_pwdata[15:0];
            `HSA_OFF_POS_GAIN: pos_gain_ff <= i_pwdata[15:0];
            `HSA_OFF_TRQ_SCALE: trq_scale_ff <= i_pwdata[15:0];
            `HSA_OFF_FIX_VAL: fix_val_ff <= i_pwdata[15:0];
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // read mux and address check, evaluated in the first access cycle
   reg [31:0] rd_word;
   reg rd_bad;
   always @* begin
      rd_bad = 1'b0;
      case (i_paddr)
         `HSA_OFF_CTRL: rd_word = {28'h0000000, ctrl_ff};
         `HSA_OFF_POS_ZERO: rd_word = {16'h0000, pos_zero_ff};
         `HSA_OFF_POS_GAIN: rd_word = {16'h0000, pos_gain_ff};
         `HSA_OFF_TRQ_SCALE: rd_word = {16'h0000, trq_scale_ff};
         `HSA_OFF_FIX_VAL: rd_word = {16'h0000, fix_val_ff};
         `HSA_OFF_DEV_STAT: rd_word = {24'h000000, dev_status_ff};
         `HSA_OFF_PV_SV: rd_word = {sv_ff, pv_ff};
         `HSA_OFF_TV_QV: rd_word = {qv_ff, tv_ff};
         12'h020: rd_word = ext_ff[31:0];
         12'h024: rd_word = ext_ff[63:32];
         12'h028: rd_word = ext_ff[95:64];
         12'h02c: rd_word = ext_ff[127:96];
         `HSA_OFF_EXT4: rd_word = {8'h00, ext_ff[151:128]};
         default: begin
            rd_word = 32'h00000000;
            rd_bad = 1'b1;
         end
      endcase
   end

   // one wait state: pready rises in the second access cycle, then falls
   // read data is captured with pready so the mux never has to hold
   // its address stable past the access; the cost is one extra cycle.
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else if (i_ce) begin
         if (apb_access && !pready_ff) begin
            pready_ff <= 1'b1;
            prdata_ff <= i_pwrite ? 32'h00000000 : rd_word;
            pslverr_ff <= rd_bad | (i_pwrite & (i_paddr > `HSA_OFF_FIX_VAL));
         end else begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // nothing here can start a reply on its own: values only wait to be read
   assign o_pready = pready_ff;
   assign o_prdata = prdata_ff;
   assign o_pslverr = pslverr_ff;
   assign o_selftest_req = st_req_ff;
   assign o_pv = pv_ff;
   assign o_sv = sv_ff;
   assign o_tv = tv_ff;
   assign o_qv = qv_ff;
   assign o_tv_dvn = tv_dvn_ff;
   assign o_qv_dvn = qv_dvn_ff;
   assign o_tv_unit = tv_unit_ff;
   assign o_dev_status = dev_status_ff; // RULE20
   assign o_ext_status = ext_ff;

endmodule // hsa_status

// ===== verification/hsa_status_sva.sv
// hsa_status_sva.sv: concurrent checks on the status outputs of hsa_status
// assumes: bound into hsa_status, single clock, synchronous active-low reset
`timescale 1ns/100ps
`include "hsa_defines.vh"

module hsa_status_sva (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_reset_cmd,
   input wire i_selftest_done,
   input wire o_selftest_req,
   input wire [7:0] o_tv_unit,
   input wire [7:0] o_dev_status,
   input wire [8*`HSA_EXT_BYTES-1:0] o_ext_status
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // condition field and drive detail, both feed the summary bits
   wire [45:0] cnd = o_ext_status[45:0];
   wire any_drv = |o_ext_status[151:112];

   AST_MORE: assert property (o_dev_status[4] == (|cnd || any_drv)) else $error("more status bit wrong");
   AST_ALERT: assert property (o_dev_status[7] == o_ext_status[49]) else $error("alert bit wrong");
   AST_WARN: assert property (o_ext_status[48] == (|(cnd & ~`HSA_ALARM_MASK) || any_drv))
      else $error("warning summary wrong");
   AST_ALARM: assert property (o_ext_status[49] == |(cnd & `HSA_ALARM_MASK)) else $error("alarm summary wrong");
   AST_ZERO: assert property (o_ext_status[111:50] == 62'h0 && o_ext_status[47:46] == 2'h0
      && (o_dev_status & 8'h6f) == 8'h00) else $error("unused status bits set");
   AST_UNIT: assert property (o_tv_unit == `HSA_UNIT_TORQUE) else $error("torque unit wrong");
   AST_RST_ST: assert property (i_ce && i_reset_cmd |=> o_selftest_req) else $error("no self-test request");
   // background only sets: a bit may drop only two edges after a self-test load
   AST_STICKY: assert property (i_ce && !i_selftest_done && !$past(i_selftest_done)
      |=> ($past(cnd) & ~cnd) == 46'h0) else $error("status bit cleared");
endmodule // hsa_status_sva

bind hsa_status hsa_status_sva chk_u (.*);

// ===== verification/hsa_st_model.sv
// hsa_st_model.sv: stand-in for the self-test engine beside the status core
// assumes: request pulses come from the core, result set staged by the bench
`timescale 1ns/100ps

module hsa_st_model #(
   parameter P_LAT = 3
) (
   input wire i_clk,
   input wire i_req,
   input wire [45:0] i_cond,
   input wire [39:0] i_drv,
   output logic o_done,
   output wire [45:0] o_cond,
   output wire [39:0] o_drv
);
   int cnt = 0;
   initial o_done = 1'b0;
   // each request restarts the run; done pulses once when it ends
   always @(posedge i_clk) begin
      o_done <= (cnt == 1);
      if (i_req)
         cnt <= P_LAT;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
   // results only mean something with done, so show garbage otherwise
   assign o_cond = o_done ? i_cond : ~i_cond;
   assign o_drv = o_done ? i_drv : ~i_drv;
endmodule // hsa_st_model

// ===== verification/hart_status_aggregator_tb_top.sv
// hart_status_aggregator_tb_top.sv: self-checking bench for hsa_status
// assumes: apb master in the bench, self-test engine model, default fit masks
`timescale 1ns/100ps
`include "hsa_defines.vh"

module hart_status_aggregator_tb_top;
   logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_reset_cmd = 0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, rd;
   logic er;
   logic [45:0] i_bg_cond = 46'h0, st_cond = 46'h0;
   logic [39:0] i_bg_drv = 40'h0, st_drv = 40'h0;
   logic [15:0] i_ctl_ua = 16'h0fa0, i_acc_ua = 16'h0fa0, i_pos_raw = 16'h0, i_close_press = 16'h0;
   logic [15:0] i_open_press = 16'h0, i_pos2 = 16'h1234, i_press2 = 16'h0abc;
   wire o_pready, o_pslverr, o_selftest_req, i_selftest_done;
   wire [31:0] o_prdata;
   wire [45:0] i_selftest_cond;
   wire [39:0] i_selftest_drv;
   wire [15:0] o_pv, o_sv, o_tv, o_qv;
   wire [7:0] o_tv_dvn, o_qv_dvn, o_tv_unit, o_dev_status;
   wire [151:0] o_ext_status;
   int mismatches = 0, n_tests = 0;

   hsa_status dut_u (.*);
   hsa_st_model st_u (.i_clk(i_clk), .i_req(o_selftest_req), .i_cond(st_cond), .i_drv(st_drv),
      .o_done(i_selftest_done), .o_cond(i_selftest_cond), .o_drv(i_selftest_drv));

   always #2 i_clk = ~i_clk;

   task chk(input string n, input logic [151:0] e, input logic [151:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_pready !== 1'b1 && k < 40);
      if (k >= 40)
         mismatches++;
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task wait_st;
      int k;
      k = 0;
      while (i_selftest_done !== 1'b1 && k < 30) begin
         @(posedge i_clk);
         k++;
      end
      // a self-test that never finishes is a failure, not a silent pass
      if (k >= 30)
         mismatches++;
      repeat (3) @(posedge i_clk);
   endtask

   // expected status image worked out from the class of each bit
   task chk_st(input logic [45:0] c, input logic [39:0] d);
      logic a, w;
      a = |(c & `HSA_ALARM_MASK);
      w = |(c & ~`HSA_ALARM_MASK) | |d;
      chk("ext_status", {d, 62'h0, a, w, 2'h0, c}, o_ext_status);
      chk("dev_status", {a, 2'h0, |{c, d}, 4'h0}, o_dev_status);
   endtask

   task t_regs;
      apb(0, `HSA_OFF_TRQ_SCALE, 0);
      chk("trq_scale", 32'h00000100, rd);
      apb(0, `HSA_OFF_CTRL, 0);
      chk("ctrl", 32'h0, rd);
      apb(0, 12'h040, 0);
      chk("unmapped err", 1'b1, er);
      apb(1, `HSA_OFF_DEV_STAT, 32'hff);
      chk("ro write err", 1'b1, er);
   endtask

   task t_vars;
      i_ctl_ua <= 16'd12000;
      i_acc_ua <= 16'd20000;
      i_close_press <= 16'd100;
      i_open_press <= 16'd300;
      i_pos_raw <= 16'h2100;
      apb(1, `HSA_OFF_POS_ZERO, 32'h100);
      apb(1, `HSA_OFF_POS_GAIN, 32'h8000);
      repeat (4) @(posedge i_clk);
      chk("pv", 16'd5000, o_pv);
      chk("sv", 16'h1000, o_sv);
      chk("tv neg", 16'hff38, o_tv);
      chk("qv full", 16'd3000, o_qv);
      chk("dvn", 16'h0203, {o_tv_dvn, o_qv_dvn});
      apb(0, `HSA_OFF_PV_SV, 0);
      chk("pv_sv reg", {16'h1000, 16'd5000}, rd);
      i_ctl_ua <= 16'd3000;
      i_close_press <= 16'd300;
      i_open_press <= 16'd100;
      i_acc_ua <= 16'd8000;
      repeat (4) @(posedge i_clk);
      chk("pv low", 16'h0, o_pv);
      chk("tv pos", 16'h00c8, o_tv);
      chk("qv mid", 16'd750, o_qv);
   endtask

   task t_subst;
      apb(1, `HSA_OFF_FIX_VAL, 32'h55aa);
      apb(1, `HSA_OFF_CTRL, 32'h9);
      repeat (4) @(posedge i_clk);
      chk("tv alt qv fix", 48'h04_1234_06_55aa, {o_tv_dvn, o_tv, o_qv_dvn, o_qv});
      apb(1, `HSA_OFF_CTRL, 32'h6);
      repeat (4) @(posedge i_clk);
      chk("tv fix qv alt", 48'h06_55aa_05_0abc, {o_tv_dvn, o_tv, o_qv_dvn, o_qv});
      apb(1, `HSA_OFF_CTRL, 32'hf);
      repeat (4) @(posedge i_clk);
      chk("fix over alt", 48'h06_55aa_06_55aa, {o_tv_dvn, o_tv, o_qv_dvn, o_qv});
   endtask

   task t_status;
      chk_st(46'h0, 40'h0);
      i_bg_cond <= 46'h1;
      repeat (2) @(posedge i_clk);
      i_bg_cond <= 46'h0;
      repeat (3) @(posedge i_clk);
      chk_st(46'h1, 40'h0);
      i_bg_cond <= 46'h400;
      i_bg_drv <= 40'h80_0000_0000;
      @(posedge i_clk);
      i_bg_cond <= 46'h0;
      i_bg_drv <= 40'h0;
      repeat (3) @(posedge i_clk);
      chk_st(46'h401, 40'h80_0000_0000);
      // host sees more-status and fetches extended words 0 and 4
      apb(0, `HSA_OFF_EXT0, 0);
      chk("ext word0", 32'h00000401, rd);
      apb(0, `HSA_OFF_EXT4, 0);
      chk("ext word4", 32'h00800000, rd);
      // clock enable low must freeze the status set
      i_ce <= 1'b0;
      i_bg_cond <= 46'h4;
      repeat (3) @(posedge i_clk);
      chk_st(46'h401, 40'h80_0000_0000);
      i_ce <= 1'b1;
      @(posedge i_clk);
      i_bg_cond <= 46'h0;
      repeat (3) @(posedge i_clk);
      chk_st(46'h405, 40'h80_0000_0000);
      st_cond <= 46'h2000;
      st_drv <= 40'h00_0010_0001;
      apb(1, `HSA_OFF_CTRL, 32'h100);
      wait_st;
      chk_st(46'h2000, 40'h00_0010_0001);
      st_cond <= 46'h0;
      st_drv <= 40'h0;
      i_reset_cmd <= 1'b1;
      @(posedge i_clk);
      i_reset_cmd <= 1'b0;
      wait_st;
      chk_st(46'h0, 40'h0);
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      t_regs;
      t_vars;
      t_subst;
      t_status;
      close_out;
   end

   // whole run needs well under 1000 cycles
   initial begin
      #40000;
      mismatches++;
      close_out;
   end
endmodule // hart_status_aggregator_tb_top
